// ### rtl/pdc_cfg.svh
// Purpose: Constants for the controller command interpreter and its host
// Assumes: Command area is a word array; codes are BCD-like hex words
// Notes: Parameters are two words, upper then lower
`ifndef PDC_CFG_SVH
`define PDC_CFG_SVH
`define PDC_CMD_IMG_DISP 16'h5030
`define PDC_CMD_IN_STATE 16'h7010
`define PDC_CMD_OUT_STATE 16'h7020
`define PDC_CMD_TERM 16'h8010
`define PDC_CMD_SUB 16'h0030
`define PDC_RESULT_OK 32'h0000_0000
`define PDC_RESULT_NG 32'hFFFF_FFFF
`define PDC_RESP_CODE 16'h0000
`define PDC_NUM_WORDS 8
`define PDC_NUM_MODULES 5
`define PDC_NUM_DO 16
`define PDC_NUM_WIN 5
`define PDC_LAYOUT_ONE 2'h0
`define PDC_LAYOUT_TWO 2'h1
`define PDC_LAYOUT_FOUR 2'h2
`define PDC_LAYOUT_THUMB 2'h3
`define PDC_MODE_LIVE 2'h0
`define PDC_MODE_FREEZE 2'h1
`define PDC_MODE_LAST_NG 2'h2
`define PDC_TT_RUN 32'h3
`define PDC_TT_FAULT 32'h4
`define PDC_TT_BUSY 32'h5
`define PDC_TT_JUDGE 32'h6
`define PDC_TT_STROBE 32'h7
`define PDC_TT_READY 32'h8
`define PDC_TT_GENERAL 32'h9
`define PDC_MOD_REMOTE 32'h4
`define PDC_PAIR_MAX 32'h1
`define PDC_DO_MAX 32'hF
`endif

// ### rtl/pdc_pkg.sv
// Purpose: Shared types of the command interpreter
// Assumes: Included constants header
// Notes: Parameters are 32-bit words made of two command words
package pdc_pkg;
	typedef logic [15:0] pdc_word_t;
	typedef logic [31:0] pdc_param_t;
	typedef enum logic [1:0] {PDC_IDLE, PDC_EXEC, PDC_RESP} pdc_state_e;
	typedef enum logic [1:0] {PDH_IDLE, PDH_WAIT, PDH_DONE} pdc_hstate_e;
endpackage

// ### rtl/pdc_if.sv
// Purpose: Command and response area between controller and host logic
// Assumes: One clock, both ends synchronous
// Notes: cmd_valid held until resp_valid pulse
`include "pdc_cfg.svh"
interface pdc_if (
	input wire logic sys_clk
);
	import pdc_pkg::*;
	logic cmd_valid;
	pdc_word_t cmd_word [`PDC_NUM_WORDS];
	logic resp_valid;
	pdc_word_t resp_word [4];
	modport dev (input cmd_valid, input cmd_word,
		output resp_valid, output resp_word);
	modport host (output cmd_valid, output cmd_word,
		input resp_valid, input resp_word);
endinterface

// ### rtl/pdc_host.sv
// Purpose: Host end, places a command and collects the response
// Assumes: User holds operands stable while busy
// Notes: One command in flight at a time
`include "pdc_cfg.svh"
module pdc_host
	import pdc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// User request
	input wire logic go,
	input wire logic [15:0] code,
	input wire logic [31:0] p0,
	input wire logic [31:0] p1,
	input wire logic [31:0] p2,
	// User answer
	output logic busy,
	output logic done,
	output logic ok,
	output logic [15:0] echo_code,
	// Command area
	pdc_if.host link
);
	typedef struct packed {
		pdc_hstate_e st;
		logic valid;
		logic [7:0][15:0] w;
		logic busy;
		logic done;
		logic ok;
		logic [15:0] echo;
	} pdc_host_s;
	pdc_host_s s_r, s_nxt;

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		case (s_r.st)
			PDH_IDLE: begin
				if (go) begin
					s_nxt.w = {p2[15:0], p2[31:16], p1[15:0], p1[31:16],
						p0[15:0], p0[31:16], `PDC_CMD_SUB, code}; // [R1] [R5] [R9] [R11]
					s_nxt.valid = 1'b1;
					s_nxt.busy = 1'b1;
					s_nxt.st = PDH_WAIT;
				end
			end
			PDH_WAIT: begin
				if (link.resp_valid) begin
					s_nxt.valid = 1'b0;
					s_nxt.echo = link.resp_word[0];
					// Word 2 is the response code, word 3 the result
					s_nxt.ok = (link.resp_word[3] == 16'(`PDC_RESULT_OK));
					s_nxt.st = PDH_DONE;
				end
			end
			PDH_DONE: begin
				s_nxt.busy = 1'b0;
				s_nxt.done = 1'b1;
				s_nxt.st = PDH_IDLE;
			end
			default: s_nxt.st = PDH_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign link.cmd_valid = s_r.valid;
	for (genvar i = 0; i < `PDC_NUM_WORDS; i++) begin : g_w
		assign link.cmd_word[i] = s_r.w[i];
	end
	assign busy = s_r.busy;
	assign done = s_r.done;
	assign ok = s_r.ok;
	assign echo_code = s_r.echo;
endmodule

// ### rtl/pdc_dev.sv
// Purpose: Controller end, decodes commands and writes responses
// Assumes: Host holds command until the response pulse
// Notes: Bad parameters answer NG and change nothing
// Function
// [R1] 5030/0030 selects image display mode change
// [R2] Window number checked against current layout
// [R3] Mode 0 live, 1 frozen, 2 last rejected
// [R4] Response echoes code, response code, OK/NG
// [R5] 7010 with module type 0 to 4
// [R6] Input state 0 prohibits, 1 permits
// [R7] Prohibited module input is ignored
// [R8] Hardware trigger inputs never blocked
// [R9] 7020 output state 0 prohibits, 1 permits
// [R10] Output prohibited stops every module transmitting
// [R11] 8010 with terminal type 3 to 9
// [R12] Terminal number limited per terminal type
// [R13] Terminal driven by state 0 or 1
// [R14] Out of range gives NG, no change
`include "pdc_cfg.svh"
module pdc_dev
	import pdc_pkg::*;
#(
	parameter int NUM_MOD = `PDC_NUM_MODULES,
	parameter int NUM_DO = `PDC_NUM_DO
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Display layout in force
	input wire logic [1:0] layout,
	// Communication traffic per module
	input wire logic [NUM_MOD-1:0] mod_rx_in,
	input wire logic [NUM_MOD-1:0] mod_tx_req,
	// Hardware triggers, pins
	input wire logic meas_trigger,
	input wire logic data_output_request,
	input wire logic fieldbus_trigger,
	// Gated traffic and trigger outputs
	output logic [NUM_MOD-1:0] mod_rx_ok,
	output logic [NUM_MOD-1:0] mod_tx_ok,
	output logic trig_out,
	output logic dor_out,
	output logic fb_trig_out,
	// Display and terminals
	output logic [1:0] win_mode [`PDC_NUM_WIN],
	output logic run_ind,
	output logic fault_ind,
	output logic busy_ind,
	output logic [1:0] judge,
	output logic [1:0] strobe,
	output logic [1:0] ready,
	output logic [NUM_DO-1:0] gen_out,
	// Command area
	pdc_if.dev link
);
	// ---------------------------------------------------------------
	// Parameter check
	// ---------------------------------------------------------------
	// Module decode is fixed at five types; outputs fit 16 terminals
	if (NUM_MOD != `PDC_NUM_MODULES || NUM_DO < 1
		|| NUM_DO > `PDC_NUM_DO) begin : g_bad_param
		$error("pdc_dev: unsupported parameters");
	end

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		pdc_state_e st;
		logic [`PDC_NUM_WIN-1:0][1:0] mode;
		logic [NUM_MOD-1:0] in_en;
		logic out_en;
		logic [2:0] sys_term;
		logic [1:0] judge, strobe, ready;
		logic [NUM_DO-1:0] gen;
		logic resp_v;
		logic [3:0][15:0] resp;
		logic [NUM_MOD-1:0] rx_ok, tx_ok;
		logic [2:0] trig_s1, trig_s2, trig_o;
	} pdc_s;
	pdc_s s_r, s_nxt;

	pdc_param_t a, b, c;
	logic good;
	logic [15:0] cw0;

	// ---------------------------------------------------------------
	// Decode and execute
	// ---------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		a = {link.cmd_word[2], link.cmd_word[3]};
		b = {link.cmd_word[4], link.cmd_word[5]};
		c = {link.cmd_word[6], link.cmd_word[7]};
		cw0 = link.cmd_word[0];
		good = 1'b0;
		s_nxt.resp_v = 1'b0;
		// Pins pass three flops; trigger path ignores prohibition
		s_nxt.trig_s1 = {fieldbus_trigger, data_output_request,
			meas_trigger};
		s_nxt.trig_s2 = s_r.trig_s1;
		s_nxt.trig_o = s_r.trig_s2; // [R8]
		s_nxt.rx_ok = mod_rx_in & s_r.in_en; // [R7]
		s_nxt.tx_ok = mod_tx_req & {NUM_MOD{s_r.out_en}}; // [R10]
		case (s_r.st)
			PDC_IDLE: begin
				if (link.cmd_valid)
					s_nxt.st = PDC_EXEC;
			end
			PDC_EXEC: begin
				if (link.cmd_word[1] == `PDC_CMD_SUB) begin
					case (cw0)
						`PDC_CMD_IMG_DISP: begin // [R1]
							case (layout) // [R2]
								`PDC_LAYOUT_ONE: good = (a == 32'h1);
								`PDC_LAYOUT_TWO: good = (a == 32'h1) || (a == 32'h2);
								`PDC_LAYOUT_FOUR: good = (a >= 32'h1) && (a <= 32'h4);
								default: good = (a <= 32'h4);
							endcase
							good = good && (b <= 32'(`PDC_MODE_LAST_NG)); // [R3] [R14]
							if (good)
								s_nxt.mode[a[2:0]] = b[1:0]; // [R3]
						end
						`PDC_CMD_IN_STATE: begin // [R5]
							good = (a <= `PDC_MOD_REMOTE) && (b <= 32'h1); // [R14]
							if (good)
								s_nxt.in_en[a[2:0]] = b[0]; // [R6]
						end
						`PDC_CMD_OUT_STATE: begin // [R9]
							good = (a <= 32'h1); // [R14]
							if (good)
								s_nxt.out_en = a[0]; // [R9]
						end
						`PDC_CMD_TERM: begin // [R11]
							good = (c <= 32'h1); // [R14]
							case (a) // [R12]
								`PDC_TT_RUN, `PDC_TT_FAULT, `PDC_TT_BUSY:
									good = good && (b == 32'h0);
								`PDC_TT_JUDGE, `PDC_TT_STROBE, `PDC_TT_READY:
									good = good && (b <= `PDC_PAIR_MAX);
								`PDC_TT_GENERAL:
									good = good && (b < 32'(NUM_DO)) && (b <= `PDC_DO_MAX);
								default: good = 1'b0;
							endcase
							if (good) begin // [R13]
								case (a)
									`PDC_TT_RUN: s_nxt.sys_term[0] = c[0];
									`PDC_TT_FAULT: s_nxt.sys_term[1] = c[0];
									`PDC_TT_BUSY: s_nxt.sys_term[2] = c[0];
									`PDC_TT_JUDGE: s_nxt.judge[b[0]] = c[0];
									`PDC_TT_STROBE: s_nxt.strobe[b[0]] = c[0];
									`PDC_TT_READY: s_nxt.ready[b[0]] = c[0];
									default: s_nxt.gen[b[3:0]] = c[0];
								endcase
							end
						end
						default: good = 1'b0;
					endcase
				end
				// Unknown commands answer NG as well
				s_nxt.resp[0] = cw0; // [R4]
				s_nxt.resp[1] = link.cmd_word[1]; // [R4]
				s_nxt.resp[2] = `PDC_RESP_CODE; // [R4]
				s_nxt.resp[3] = good ? 16'(`PDC_RESULT_OK)
					: 16'(`PDC_RESULT_NG); // [R4]
				s_nxt.resp_v = 1'b1;
				s_nxt.st = PDC_RESP;
			end
			PDC_RESP: begin
				// Wait for host to drop the request, avoids re-execution
				if (!link.cmd_valid)
					s_nxt.st = PDC_IDLE;
			end
			default: s_nxt.st = PDC_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			s_r <= '0;
			s_r.in_en <= '1;
			s_r.out_en <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign link.resp_valid = s_r.resp_v;
	assign link.resp_word[0] = s_r.resp[0];
	assign link.resp_word[1] = s_r.resp[1];
	// Response code word first, then the result word
	assign link.resp_word[2] = s_r.resp[2];
	assign link.resp_word[3] = s_r.resp[3];
	for (genvar i = 0; i < `PDC_NUM_WIN; i++) begin : g_win
		assign win_mode[i] = s_r.mode[i];
	end
	assign mod_rx_ok = s_r.rx_ok;
	assign mod_tx_ok = s_r.tx_ok;
	assign trig_out = s_r.trig_o[0];
	assign dor_out = s_r.trig_o[1];
	assign fb_trig_out = s_r.trig_o[2];
	assign run_ind = s_r.sys_term[0];
	assign fault_ind = s_r.sys_term[1];
	assign busy_ind = s_r.sys_term[2];
	assign judge = s_r.judge;
	assign strobe = s_r.strobe;
	assign ready = s_r.ready;
	assign gen_out = s_r.gen;
endmodule

// ### verification/pdc_io_chk.sv
// Purpose: Checks on the command area between host and device
// Assumes: Single clock, nrst synchronous active low
// Notes: Sees only the interface signals
`include "pdc_cfg.svh"
module pdc_io_chk
	import pdc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Command area
	input wire logic cmd_valid,
	input wire pdc_word_t cmd_word [`PDC_NUM_WORDS],
	input wire logic resp_valid,
	input wire pdc_word_t resp_word [4]
);
	logic [31:0] pa;
	logic [31:0] pb;
	logic ng;
	logic sub_ok;
	assign pa = {cmd_word[2], cmd_word[3]};
	assign pb = {cmd_word[4], cmd_word[5]};
	// Word 2 is the fixed response code, word 3 the result
	assign ng = resp_valid && resp_word[3] == 16'(`PDC_RESULT_NG);
	assign sub_ok = cmd_word[1] == `PDC_CMD_SUB;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	property p_one_shot;
		resp_valid |=> !resp_valid;
	endproperty
	a_one_shot: assert property (p_one_shot)
		else $error("response pulse longer than one cycle");
	property p_latency;
		$rose(cmd_valid) |-> !resp_valid ##2 resp_valid;
	endproperty
	a_latency: assert property (p_latency)
		else $error("response not two cycles after command");
	property p_echo;
		resp_valid |-> resp_word[0] == cmd_word[0] &&
			resp_word[1] == cmd_word[1];
	endproperty
	a_echo: assert property (p_echo)
		else $error("command code not echoed");
	property p_result;
		resp_valid |-> resp_word[2] == `PDC_RESP_CODE &&
			(resp_word[3] == 16'(`PDC_RESULT_OK) || ng);
	endproperty
	a_result: assert property (p_result)
		else $error("result word malformed");
	property p_unknown;
		resp_valid && !(sub_ok && cmd_word[0] inside {`PDC_CMD_IMG_DISP,
			`PDC_CMD_IN_STATE, `PDC_CMD_OUT_STATE, `PDC_CMD_TERM}) |-> ng;
	endproperty
	a_unknown: assert property (p_unknown)
		else $error("unknown code not refused");
	property p_mode;
		resp_valid && cmd_word[0] == `PDC_CMD_IMG_DISP &&
			pb > 32'(`PDC_MODE_LAST_NG) |-> ng;
	endproperty
	a_mode: assert property (p_mode)
		else $error("bad image mode not refused");
	property p_module;
		resp_valid && cmd_word[0] == `PDC_CMD_IN_STATE &&
			pa > `PDC_MOD_REMOTE |-> ng;
	endproperty
	a_module: assert property (p_module)
		else $error("bad module type not refused");
	property p_term;
		resp_valid && cmd_word[0] == `PDC_CMD_TERM &&
			!(pa inside {[`PDC_TT_RUN:`PDC_TT_GENERAL]}) |-> ng;
	endproperty
	a_term: assert property (p_term)
		else $error("bad terminal type not refused");
	property p_out_ok;
		resp_valid && sub_ok && cmd_word[0] == `PDC_CMD_OUT_STATE &&
			pa <= 32'h1 |-> !ng;
	endproperty
	a_out_ok: assert property (p_out_ok)
		else $error("valid output state refused");
endmodule

// ### verification/plc_display_comm_io_commands_tb.sv
// Purpose: Bench driving host end against device end
// Assumes: Inputs change on falling edge
// Notes: Refused commands must leave outputs unchanged
`include "pdc_cfg.svh"
module plc_display_comm_io_commands_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk, nrst, go, busy, done, ok, trig, dor, fbt;
	logic run_i, flt_i, bsy_i, meas, dreq, fbin;
	logic [15:0] code, echo, gen;
	logic [31:0] pa, pb, pc;
	logic [1:0] layout, judge, strobe, ready;
	logic [1:0] win [`PDC_NUM_WIN];
	logic [4:0] rx, tx, rx_ok, tx_ok;
	int mismatches, check_count;
	pdc_if link_if (.sys_clk(sys_clk));
	pdc_host pdc_host_inst (.sys_clk(sys_clk), .nrst(nrst), .go(go),
		.code(code), .p0(pa), .p1(pb), .p2(pc), .busy(busy), .done(done),
		.ok(ok), .echo_code(echo), .link(link_if.host));
	pdc_dev pdc_dev_inst (.sys_clk(sys_clk), .nrst(nrst), .layout(layout),
		.mod_rx_in(rx), .mod_tx_req(tx), .meas_trigger(meas),
		.data_output_request(dreq), .fieldbus_trigger(fbin),
		.mod_rx_ok(rx_ok), .mod_tx_ok(tx_ok), .trig_out(trig), .dor_out(dor),
		.fb_trig_out(fbt), .win_mode(win), .run_ind(run_i),
		.fault_ind(flt_i), .busy_ind(bsy_i), .judge(judge),
		.strobe(strobe), .ready(ready), .gen_out(gen), .link(link_if.dev));
	pdc_io_chk pdc_io_chk_inst (.sys_clk(sys_clk), .nrst(nrst),
		.cmd_valid(link_if.cmd_valid), .cmd_word(link_if.cmd_word),
		.resp_valid(link_if.resp_valid), .resp_word(link_if.resp_word));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cmd(logic [15:0] c, logic [31:0] a, b, d, logic exp_ok);
		code = c;
		pa = a;
		pb = b;
		pc = d;
		go = 1'b1;
		@(negedge sys_clk);
		go = 1'b0;
		check("busy", busy, 1'b1);
		for (int i = 0; i < 20 && done !== 1'b1; i++) @(negedge sys_clk);
		check("done", done, 1'b1);
		check("busy_end", busy, 1'b0);
		check("ok", ok, exp_ok);
		check("echo", echo, c);
	endtask
	function automatic logic term(int t, int n);
		case (t)
			3: return run_i;
			4: return flt_i;
			5: return bsy_i;
			6: return judge[n];
			7: return strobe[n];
			8: return ready[n];
			default: return gen[n];
		endcase
	endfunction
	task automatic t_image();
		layout = 2'h1;
		cmd(16'h5030, 32'h2, 32'h2, 32'h0, 1'b1);
		check("win2", win[2], 2'h2);
		cmd(16'h5030, 32'h3, 32'h1, 32'h0, 1'b0);
		check("win3", win[3], 2'h0);
		cmd(16'h5030, 32'h1, 32'h3, 32'h0, 1'b0);
		check("win1", win[1], 2'h0);
		layout = 2'h2;
		cmd(16'h5030, 32'h4, 32'h1, 32'h0, 1'b1);
		check("win4", win[4], 2'h1);
		layout = 2'h3;
		cmd(16'h5030, 32'h0, 32'h1, 32'h0, 1'b1);
		check("win0_on", win[0], 2'h1);
		cmd(16'h5030, 32'h0, 32'h0, 32'h0, 1'b1);
		check("win0", win[0], 2'h0);
		cmd(16'h4321, 32'h0, 32'h0, 32'h0, 1'b0);
	endtask
	task automatic t_comm();
		rx = 5'h1F;
		tx = 5'h1F;
		{meas, dreq, fbin} = 3'h7;
		cmd(16'h7010, 32'h2, 32'h0, 32'h0, 1'b1);
		check("rx_ok", rx_ok, 5'h1B);
		check("trig", {trig, dor, fbt}, 3'h7);
		cmd(16'h7010, 32'h5, 32'h1, 32'h0, 1'b0);
		cmd(16'h7010, 32'h2, 32'h2, 32'h0, 1'b0);
		check("rx_kept", rx_ok, 5'h1B);
		cmd(16'h7010, 32'h2, 32'h1, 32'h0, 1'b1);
		check("rx_back", rx_ok, 5'h1F);
		cmd(16'h7020, 32'h0, 32'h0, 32'h0, 1'b1);
		check("tx_off", tx_ok, 5'h00);
		check("trig_tx", {trig, dor, fbt}, 3'h7);
		cmd(16'h7020, 32'h2, 32'h0, 32'h0, 1'b0);
		check("tx_kept", tx_ok, 5'h00);
		cmd(16'h7020, 32'h1, 32'h0, 32'h0, 1'b1);
		check("tx_on", tx_ok, 5'h1F);
	endtask
	task automatic t_term();
		int nmax;
		for (int t = 3; t <= 9; t++) begin
			nmax = (t < 6) ? 0 : (t < 9) ? 1 : 15;
			cmd(16'h8010, t, nmax, 32'h1, 1'b1);
			check("term_on", term(t, nmax), 1'b1);
			cmd(16'h8010, t, nmax + 1, 32'h0, 1'b0);
			check("term_kept", term(t, nmax), 1'b1);
			cmd(16'h8010, t, nmax, 32'h0, 1'b1);
			check("term_off", term(t, nmax), 1'b0);
		end
		cmd(16'h8010, 32'h2, 32'h0, 32'h1, 1'b0);
	endtask
	// Mid-run reset must bring back permitted traffic and cleared windows
	task automatic t_reset();
		cmd(16'h7010, 32'h0, 32'h0, 32'h0, 1'b1);
		check("rx_off0", rx_ok, 5'h1E);
		nrst = 1'b0;
		repeat (2) @(negedge sys_clk);
		nrst = 1'b1;
		repeat (2) @(negedge sys_clk);
		check("rx_rst", rx_ok, 5'h1F);
		check("tx_rst", tx_ok, 5'h1F);
		check("win_rst", win[2], 2'h0);
		cmd(16'h7020, 32'h0, 32'h0, 32'h0, 1'b1);
		check("tx_off2", tx_ok, 5'h00);
	endtask
	task automatic close_out();
		$display("Checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		nrst = 1'b0;
		{go, meas, dreq, fbin} = 4'h0;
		{code, pa, pb, pc} = '0;
		{layout, rx, tx} = '0;
		mismatches = 0;
		check_count = 0;
		repeat (2) @(negedge sys_clk);
		nrst = 1'b1;
		t_image();
		t_comm();
		t_term();
		t_reset();
		close_out();
	end
	// Hang guard, far above the few hundred cycles needed
	initial begin
		repeat (5000) @(posedge sys_clk);
		mismatches++;
		close_out();
	end
endmodule
